// *** hdl/seq_action_consts.svh ***
`ifndef SEQ_ACTION_CONSTS_SVH
`define SEQ_ACTION_CONSTS_SVH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_LOCAL_ADDR  8'h04
`define OFS_FORM        8'h08
`define OFS_YN_A        8'h0c
`define OFS_RULE_B      8'h10
`define OFS_CMD         8'h14
`define OFS_ARG         8'h18
`define OFS_STATUS      8'h1c
`define OFS_MASK        8'h20
`define OFS_ERRCODE     8'h24
`define OFS_OUTPUTS     8'h28

// ctrl fields
`define CTRL_ENABLE_BIT 0

// rule b fields
`define RULEB_EN_LSB    16

// cmd fields
`define CMD_OP_LSB      0
`define CMD_OP_W        3
`define CMD_YN_BIT      3
`define CMD_KIND_LSB    4
`define CMD_KIND_W      2
`define CMD_TGT_LSB     16
`define CMD_TGT_W       16

// status bits
`define ST_DONE_BIT     0
`define ST_EXEC_ERR_BIT 1
`define ST_VAL_ERR_BIT  2
`define ST_W            3

// execution error code for a step load or stop command aimed at its own table
`define ERR_SELF_TARGET 8'h51

// write-command constant range
`define VAL_MAX         16'sh7d00
`define VAL_MIN         16'sh8300

// reset values
`define RST_WORD        32'h0000_0000

`endif

// *** hdl/seq_action_pkg.sv ***
package seq_action_pkg;

  typedef enum logic [1:0] {
    FORM_HOLD,
    FORM_NONHOLD,
    FORM_PULSE,
    FORM_FLASH
  } form_t;

  typedef enum logic [2:0] {
    OP_STEP,
    OP_RUN,
    OP_STOP,
    OP_SET,
    OP_ELEM,
    OP_RSV5,
    OP_RSV6,
    OP_RSV7
  } op_t;

  typedef enum logic [1:0] {
    KIND_DELAY,
    KIND_TALLY,
    KIND_PAUSE,
    KIND_RSV
  } elem_kind_t;

  typedef enum logic [1:0] {
    ACT_RESET_START,
    ACT_ALT_START,
    ACT_PAUSE,
    ACT_RESUME
  } elem_act_t;

endpackage : seq_action_pkg

// *** hdl/seq_action_rule.sv ***
`timescale 1ns/1ps
module seq_action_rule
  import seq_action_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // operating cycle
  input  wire logic tick,
  // conditions
  input  wire logic cond_a,
  input  wire logic cond_b,
  // configuration
  input  wire form_t form,
  input  wire logic yn_a,
  input  wire logic yn_b,
  input  wire logic en_b,
  // contact
  output logic      out_q
);

  logic prev_a_q;
  logic prev_b_q;
  logic flash_q;
  logic off_pend_q;
  logic rise_a;
  logic rise_b;

  assign rise_a = cond_a & ~prev_a_q;
  assign rise_b = en_b & cond_b & ~prev_b_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_a_q <= 1'b0;
      prev_b_q <= 1'b0;
    end else if (ce && tick) begin
      prev_a_q <= cond_a;
      prev_b_q <= cond_b;
    end
  end

  // off request from the holding rule waits for the flash condition to lapse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      off_pend_q <= 1'b0;
    end else if (ce && tick) begin
      if (form != FORM_FLASH) begin
        off_pend_q <= 1'b0;
      end else if (rise_b && !yn_b) begin
        off_pend_q <= 1'b1;
      end else if (off_pend_q && !cond_a) begin
        off_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q   <= 1'b0;
      flash_q <= 1'b0;
    end else if (ce && tick) begin
      unique case (form)
        FORM_HOLD: begin
          flash_q <= 1'b0;
          if (rise_a) begin
            out_q <= yn_a;
          end else if (rise_b) begin
            out_q <= yn_b;
          end
        end
        FORM_NONHOLD: begin
          flash_q <= 1'b0;
          out_q   <= cond_a;
        end
        FORM_PULSE: begin
          flash_q <= 1'b0;
          out_q   <= rise_a;
        end
        FORM_FLASH: begin
          if ((off_pend_q || (rise_b && !yn_b)) && !cond_a) begin
            out_q   <= 1'b0;
            flash_q <= 1'b0;
          end else if (cond_a) begin
            flash_q <= yn_a;
            out_q   <= yn_a ? ~out_q : 1'b1;
          end else if (flash_q) begin
            out_q <= ~out_q;
          end
        end
      endcase
    end
  end

endmodule : seq_action_rule

// *** hdl/seq_action_exec.sv ***
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "seq_action_consts.svh"
module seq_action_exec
  import seq_action_pkg::*;
#(
  parameter int N_OUT = 8
) (
  // clock, reset, enable
  input  wire logic                SYS_CLK,
  input  wire logic                RST,
  input  wire logic                CE,
  // operating cycle strobe and rule conditions
  input  wire logic                OP_TICK,
  input  wire logic [N_OUT-1:0]    COND_A,
  input  wire logic [N_OUT-1:0]    COND_B,
  // apb slave
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // contact outputs
  output logic      [N_OUT-1:0]    DOUT,
  // table commands
  output logic                     STEP_LOAD,
  output logic                     RUN_WR,
  output logic                     RUN_VAL,
  output logic      [15:0]         TBL_ADDR,
  output logic      [15:0]         TBL_STEP,
  // item write
  output logic                     ITEM_WR,
  output logic      [15:0]         ITEM_DEST,
  output logic      [15:0]         ITEM_VALUE,
  // element control
  output logic                     ELEM_WR,
  output elem_kind_t               ELEM_KIND,
  output logic      [15:0]         ELEM_NUM,
  output elem_act_t                ELEM_ACT,
  // interrupt
  output logic                     IRQ
);

  logic                   enable_q;
  logic [15:0]            local_addr_q;
  logic [2*N_OUT-1:0]     form_q;
  logic [N_OUT-1:0]       yn_a_q;
  logic [N_OUT-1:0]       yn_b_q;
  logic [N_OUT-1:0]       en_b_q;
  logic [31:0]            cmd_q;
  logic [15:0]            arg_q;
  logic                   pend_q;
  logic [`ST_W-1:0]       status_q;
  logic [`ST_W-1:0]       status_d;
  logic [`ST_W-1:0]       mask_q;
  logic [7:0]             errcode_q;
  logic [N_OUT-1:0]       dout_w;
  logic                   access;
  logic                   wr_en;
  logic [31:0]            rdata;
  logic                   unmapped;
  logic                   run_tick;
  logic                   exec;
  op_t                    op;
  logic                   yn;
  elem_kind_t             kind;
  logic [15:0]            tgt;
  logic                   self_hit;
  logic                   val_ok;
  logic [`ST_W-1:0]       ev;

  assign access   = PSEL & PENABLE;
  assign wr_en    = access & PREADY & PWRITE;
  assign run_tick = OP_TICK & enable_q;
  assign exec     = run_tick & pend_q;
  assign op       = op_t'(cmd_q[`CMD_OP_LSB +: `CMD_OP_W]);
  assign yn       = cmd_q[`CMD_YN_BIT];
  assign kind     = elem_kind_t'(cmd_q[`CMD_KIND_LSB +: `CMD_KIND_W]);
  assign tgt      = cmd_q[`CMD_TGT_LSB +: `CMD_TGT_W];
  assign self_hit = (tgt == local_addr_q);
  assign val_ok   = ($signed(arg_q) <= `VAL_MAX) && ($signed(arg_q) >= `VAL_MIN);

  // contact output slices
  genvar gi;
  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_rule
      seq_action_rule u_rule (
        .clk    (SYS_CLK),
        .rst    (RST),
        .ce     (CE),
        .tick   (run_tick),
        .cond_a (COND_A[gi]),
        .cond_b (COND_B[gi]),
        .form   (form_t'(form_q[2*gi +: 2])),
        .yn_a   (yn_a_q[gi]),
        .yn_b   (yn_b_q[gi]),
        .en_b   (en_b_q[gi]),
        .out_q  (dout_w[gi])
      );
    end
  endgenerate

  assign DOUT = dout_w;

  // register read mux
  always_comb begin
    rdata    = `RST_WORD;
    unmapped = 1'b0;
    unique case (PADDR)
      `OFS_CTRL:       rdata[`CTRL_ENABLE_BIT] = enable_q;
      `OFS_LOCAL_ADDR: rdata[15:0] = local_addr_q;
      `OFS_FORM:       rdata[2*N_OUT-1:0] = form_q;
      `OFS_YN_A:       rdata[N_OUT-1:0] = yn_a_q;
      `OFS_RULE_B: begin
        rdata[N_OUT-1:0]              = yn_b_q;
        rdata[`RULEB_EN_LSB +: N_OUT] = en_b_q;
      end
      `OFS_CMD:        rdata = cmd_q;
      `OFS_ARG:        rdata[15:0] = arg_q;
      `OFS_STATUS:     rdata[`ST_W-1:0] = status_q;
      `OFS_MASK:       rdata[`ST_W-1:0] = mask_q;
      `OFS_ERRCODE:    rdata[7:0] = errcode_q;
      `OFS_OUTPUTS:    rdata[N_OUT-1:0] = dout_w;
      default:         unmapped = 1'b1;
    endcase
  end

  // apb: one wait state, answer registered
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= `RST_WORD;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      if (access && !PREADY) begin
        PREADY  <= 1'b1;
        PRDATA  <= PWRITE ? `RST_WORD : rdata;
        PSLVERR <= unmapped;
      end else begin
        PREADY  <= 1'b0;
        PSLVERR <= 1'b0;
      end
    end
  end

  // control and rule configuration registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      enable_q     <= 1'b0;
      local_addr_q <= 16'h0000;
      form_q       <= '0;
      yn_a_q       <= '0;
      yn_b_q       <= '0;
      en_b_q       <= '0;
    end else if (CE && wr_en) begin
      unique case (PADDR)
        `OFS_CTRL:       enable_q <= PWDATA[`CTRL_ENABLE_BIT];
        `OFS_LOCAL_ADDR: local_addr_q <= PWDATA[15:0];
        `OFS_FORM:       form_q <= PWDATA[2*N_OUT-1:0];
        `OFS_YN_A:       yn_a_q <= PWDATA[N_OUT-1:0];
        `OFS_RULE_B: begin
          yn_b_q <= PWDATA[N_OUT-1:0];
          en_b_q <= PWDATA[`RULEB_EN_LSB +: N_OUT];
        end
        default: ;
      endcase
    end
  end

  // interrupt mask and command operand
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mask_q <= '0;
      arg_q  <= 16'h0000;
    end else if (CE && wr_en) begin
      if (PADDR == `OFS_MASK) begin
        mask_q <= PWDATA[`ST_W-1:0];
      end
      if (PADDR == `OFS_ARG) begin
        arg_q <= PWDATA[15:0];
      end
    end
  end

  // command register; a rewrite before execution replaces the pending one
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cmd_q <= `RST_WORD;
    end else if (CE && wr_en && PADDR == `OFS_CMD) begin
      cmd_q <= PWDATA;
    end
  end

  // a command write arms one execution at the next operating cycle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pend_q <= 1'b0;
    end else if (CE) begin
      if (wr_en && PADDR == `OFS_CMD) begin
        pend_q <= 1'b1;
      end else if (exec) begin
        pend_q <= 1'b0;
      end
    end
  end

  // table commands: step load and run switch writes
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      STEP_LOAD <= 1'b0;
      RUN_WR    <= 1'b0;
      RUN_VAL   <= 1'b0;
      TBL_ADDR  <= 16'h0000;
      TBL_STEP  <= 16'h0000;
    end else if (CE) begin
      STEP_LOAD <= 1'b0;
      RUN_WR    <= 1'b0;
      if (exec) begin
        unique case (op)
          OP_STEP: if (!self_hit) begin
            STEP_LOAD <= 1'b1;
            TBL_ADDR  <= tgt;
            TBL_STEP  <= arg_q;
          end
          OP_RUN: begin
            RUN_WR   <= 1'b1;
            RUN_VAL  <= 1'b1;
            TBL_ADDR <= tgt;
          end
          OP_STOP: if (!self_hit) begin
            RUN_WR   <= 1'b1;
            RUN_VAL  <= 1'b0;
            TBL_ADDR <= tgt;
          end
          default: ;
        endcase
      end
    end
  end

  // item write, dropped when the constant is out of range
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ITEM_WR    <= 1'b0;
      ITEM_DEST  <= 16'h0000;
      ITEM_VALUE <= 16'h0000;
    end else if (CE) begin
      ITEM_WR <= 1'b0;
      if (exec && op == OP_SET && val_ok) begin
        ITEM_WR    <= 1'b1;
        ITEM_DEST  <= tgt;
        ITEM_VALUE <= arg_q;
      end
    end
  end

  // element control; a reserved kind is dropped
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ELEM_WR   <= 1'b0;
      ELEM_KIND <= KIND_DELAY;
      ELEM_NUM  <= 16'h0000;
      ELEM_ACT  <= ACT_RESET_START;
    end else if (CE) begin
      ELEM_WR <= 1'b0;
      if (exec && op == OP_ELEM && kind != KIND_RSV) begin
        ELEM_WR   <= 1'b1;
        ELEM_KIND <= kind;
        ELEM_NUM  <= tgt;
        if (kind == KIND_PAUSE) begin
          ELEM_ACT <= yn ? ACT_PAUSE : ACT_RESUME;
        end else begin
          ELEM_ACT <= yn ? ACT_RESET_START : ACT_ALT_START;
        end
      end
    end
  end

  // events of this execution
  always_comb begin
    ev = '0;
    if (exec) begin
      ev[`ST_DONE_BIT]     = 1'b1;
      ev[`ST_EXEC_ERR_BIT] = self_hit && (op == OP_STEP || op == OP_STOP);
      ev[`ST_VAL_ERR_BIT]  = (op == OP_SET) && !val_ok;
    end
  end

  // sticky status, write one to clear, a new event wins over the clear
  always_comb begin
    status_d = status_q;
    if (wr_en && PADDR == `OFS_STATUS) begin
      status_d = status_q & ~PWDATA[`ST_W-1:0];
    end
    status_d = status_d | ev;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      status_q <= '0;
    end else if (CE) begin
      status_q <= status_d;
    end
  end

  // error code of the last self-aimed step load or stop command
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      errcode_q <= 8'h00;
    end else if (CE && ev[`ST_EXEC_ERR_BIT]) begin
      errcode_q <= `ERR_SELF_TARGET;
    end
  end

  // level interrupt, registered from status_d so it changes in the same cycle as the status it reflects
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |(status_d & mask_q);
    end
  end

endmodule : seq_action_exec

// *** tb/seq_action_exec_sva.sv ***
`timescale 1ns/1ps
module seq_action_exec_sva
  import seq_action_pkg::*;
#(
  parameter int N_OUT = 8
) (
  // clock and reset
  input wire logic             SYS_CLK,
  input wire logic             RST,
  // apb answer
  input wire logic             PSEL,
  input wire logic             PENABLE,
  input wire logic             PREADY,
  input wire logic             PSLVERR,
  // block side
  input wire logic             OP_TICK,
  input wire logic [N_OUT-1:0] DOUT,
  input wire logic             STEP_LOAD,
  input wire logic             RUN_WR,
  input wire logic             RUN_VAL,
  input wire logic             ITEM_WR,
  input wire logic [15:0]      ITEM_VALUE,
  input wire logic             ELEM_WR,
  input wire elem_kind_t       ELEM_KIND,
  input wire elem_act_t        ELEM_ACT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic [3:0] strb;
  assign strb = {STEP_LOAD, RUN_WR, ITEM_WR, ELEM_WR};

  property p_wait;
    PSEL && PENABLE && !PREADY |=> PREADY;
  endproperty
  a_wait: assert property (p_wait) else $error("apb answer late");
  property p_slverr;
    PSLVERR |-> PREADY && PSEL && PENABLE;
  endproperty
  a_slverr: assert property (p_slverr) else $error("error without ready");
  property p_dout_tick;
    !$past(OP_TICK) |-> $stable(DOUT);
  endproperty
  a_dout_tick: assert property (p_dout_tick) else $error("contacts moved off tick");
  property p_step_tick;
    STEP_LOAD |-> $past(OP_TICK);
  endproperty
  a_step_tick: assert property (p_step_tick) else $error("step load off tick");
  property p_run_tick;
    RUN_WR |-> $past(OP_TICK);
  endproperty
  a_run_tick: assert property (p_run_tick) else $error("run write off tick");
  property p_strb_one;
    (strb != 4'h0) |=> (strb == 4'h0);
  endproperty
  a_strb_one: assert property (p_strb_one) else $error("strobe too long");
  property p_excl;
    $onehot0(strb);
  endproperty
  a_excl: assert property (p_excl) else $error("two strobes at once");
  property p_range;
    ITEM_WR |-> $signed(ITEM_VALUE) <= 32000 && $signed(ITEM_VALUE) >= -32000;
  endproperty
  a_range: assert property (p_range) else $error("item value out of range");
  property p_elem;
    ELEM_WR && ELEM_KIND inside {KIND_DELAY, KIND_TALLY} |->
      ELEM_ACT inside {ACT_RESET_START, ACT_ALT_START};
  endproperty
  a_elem: assert property (p_elem) else $error("bad element action");
  property p_pause;
    ELEM_WR && ELEM_KIND == KIND_PAUSE |-> ELEM_ACT inside {ACT_PAUSE, ACT_RESUME};
  endproperty
  a_pause: assert property (p_pause) else $error("bad pause action");

  c_step: cover property (STEP_LOAD);
  c_stop: cover property (RUN_WR && !RUN_VAL);
  c_pause: cover property (ELEM_WR && ELEM_KIND == KIND_PAUSE);
endmodule : seq_action_exec_sva

bind seq_action_exec seq_action_exec_sva #(.N_OUT(N_OUT)) seq_action_exec_sva_inst (
  .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .OP_TICK(OP_TICK), .DOUT(DOUT), .STEP_LOAD(STEP_LOAD),
  .RUN_WR(RUN_WR), .RUN_VAL(RUN_VAL), .ITEM_WR(ITEM_WR), .ITEM_VALUE(ITEM_VALUE),
  .ELEM_WR(ELEM_WR), .ELEM_KIND(ELEM_KIND), .ELEM_ACT(ELEM_ACT));

// *** tb/test_sequence_table_action_executor.sv ***
`timescale 1ns/1ps
`include "seq_action_consts.svh"
module test_sequence_table_action_executor;
  logic        clk = 0, rst = 1, op_tick = 0, psel = 0, penable = 0, pwrite = 0, ce = 1;
  logic [7:0]  cond_a = 0, cond_b = 0, paddr = 0, dout;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, step_load, run_wr, run_val, item_wr, elem_wr, irq;
  logic [15:0] tbl_addr, tbl_step, item_dest, item_value, elem_num;
  logic [1:0]  elem_kind, elem_act;
  int          n_mismatch = 0, total_checks = 0, cyc = 0;

  seq_action_exec seq_action_exec_inst (
    .SYS_CLK(clk), .RST(rst), .CE(ce), .OP_TICK(op_tick), .COND_A(cond_a),
    .COND_B(cond_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DOUT(dout),
    .STEP_LOAD(step_load), .RUN_WR(run_wr), .RUN_VAL(run_val), .TBL_ADDR(tbl_addr),
    .TBL_STEP(tbl_step), .ITEM_WR(item_wr), .ITEM_DEST(item_dest),
    .ITEM_VALUE(item_value), .ELEM_WR(elem_wr), .ELEM_KIND(elem_kind),
    .ELEM_NUM(elem_num), .ELEM_ACT(elem_act), .IRQ(irq));

  initial forever #12.5 clk = ~clk;

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task tick(input logic a, input logic [7:0] b);
    @(posedge clk);
    op_tick <= 1; cond_a <= {8{a}}; cond_b <= b;
    @(posedge clk);
    op_tick <= 0;
    #1;
  endtask : tick

  task t_regs;
    apb(0, `OFS_STATUS, 0);
    chk(rd, 32'h0, "status reset");
    apb(0, 8'h40, 0);
    chk({err, rd[30:0]}, 32'h8000_0000, "unmapped");
    $display("regs test done");
  endtask : t_regs

  task t_outputs;
    logic [7:0] ea [6] = '{8'h20, 8'h1f, 8'h13, 8'h19, 8'h17, 8'h09};
    logic [7:0] bs [6] = '{8'h20, 8'h20, 8'h00, 8'h00, 8'h10, 8'h00};
    logic [5:0] as = 6'b010110;
    // forms: hold Y, nonhold, pulse, flash Y, flash N, hold N
    apb(1, `OFS_FORM, 32'h3e4);
    apb(1, `OFS_YN_A, 32'hf);
    apb(1, `OFS_RULE_B, 32'h0030_0020);
    apb(1, `OFS_LOCAL_ADDR, 32'h7);
    apb(1, `OFS_MASK, 32'h2);
    apb(1, `OFS_CTRL, 32'h1);
    apb(0, `OFS_FORM, 0);
    chk(rd, 32'h3e4, "form readback");
    for (int i = 0; i < 6; i++) begin
      tick(as[i], bs[i]);
      chk(dout, ea[i], "contacts");
    end
    // a tick while the clock enable is low must not move the contacts
    @(posedge clk);
    ce <= 1'b0;
    tick(1, 8'h00);
    chk(dout, 8'h09, "frozen by clock enable");
    @(posedge clk);
    ce <= 1'b1;
    $display("outputs test done");
  endtask : t_outputs

  task cmd(input logic [31:0] c, a, input logic [3:0] es, input logic [31:0] ed,
           input logic [1:0] st);
    apb(1, `OFS_ARG, a);
    apb(1, `OFS_CMD, c);
    tick(0, 8'h00);
    chk({step_load, run_wr, item_wr, elem_wr}, es, "strobes");
    case (es)
      4'h8: chk({tbl_addr, tbl_step}, ed, "step data");
      4'h4: chk({tbl_addr, 15'h0, run_val}, ed, "run data");
      4'h2: chk({item_dest, item_value}, ed, "item data");
      4'h1: chk({elem_num, 12'h0, elem_kind, elem_act}, ed, "elem data");
      default: ;
    endcase
    apb(0, `OFS_STATUS, 0);
    chk(rd[2:0], {st, 1'b1}, "status");
    chk(irq, st[0], "irq");
    if (st[0]) begin
      apb(0, `OFS_ERRCODE, 0);
      chk(rd, 32'h51, "error code");
    end
    apb(1, `OFS_STATUS, 32'h7);
    @(posedge clk);
    #1;
    chk(irq, 0, "irq clear");
  endtask : cmd

  task t_cmds;
    cmd(32'h0009_0000, 32'h5, 4'h8, 32'h0009_0005, 2'h0);
    cmd(32'h0007_0000, 32'h5, 4'h0, 32'h0, 2'h1);
    cmd(32'h0009_0001, 32'h0, 4'h4, 32'h0009_0001, 2'h0);
    cmd(32'h0009_0002, 32'h0, 4'h4, 32'h0009_0000, 2'h0);
    cmd(32'h0007_0002, 32'h0, 4'h0, 32'h0, 2'h1);
    cmd(32'h0044_0003, 32'h7d00, 4'h2, 32'h0044_7d00, 2'h0);
    cmd(32'h0044_0003, 32'h8300, 4'h2, 32'h0044_8300, 2'h0);
    cmd(32'h0044_0003, 32'h7d01, 4'h0, 32'h0, 2'h2);
    cmd(32'h0003_000c, 32'h0, 4'h1, 32'h0003_0000, 2'h0);
    cmd(32'h0003_0014, 32'h0, 4'h1, 32'h0003_0005, 2'h0);
    cmd(32'h0003_002c, 32'h0, 4'h1, 32'h0003_000a, 2'h0);
    cmd(32'h0003_0024, 32'h0, 4'h1, 32'h0003_000b, 2'h0);
    cmd(32'h0003_0034, 32'h0, 4'h0, 32'h0, 2'h0);
    $display("commands test done");
  endtask : t_cmds

  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    t_regs();
    t_outputs();
    t_cmds();
    give_verdict();
  end
endmodule : test_sequence_table_action_executor
